//--- hw/dpb_param_bank.sv
// Purpose: AHB-Lite register bank of drive parameters with range checking.
// Assumes: One AHB-Lite master, single word transfers, synchronous reset.
// Notes: Writes are zero wait; reads take one wait state.
`timescale 1ns/100ps
`default_nettype none

module dpb_param_bank (
	input  wire logic                            clk_sys_in,
	input  wire logic                            rst_in,
	input  wire logic                            hsel_in,
	input  wire logic [31:0]                     haddr_in,
	input  wire logic [1:0]                      htrans_in,
	input  wire logic                            hwrite_in,
	input  wire logic [2:0]                      hsize_in,
	input  wire logic [31:0]                     hwdata_in,
	input  wire logic                            hready_in,
	output logic      [31:0]                     hrdata_out,
	output logic                                 hreadyout_out,
	output logic                                 hresp_out,
	output logic                                 write_rejected_out,
	output logic                                 large_rating_out,
	output logic      [dpb_pkg::NUM_SLOTS*16-1:0] params_out
);

	// ----------------------------------------------------------------
	// Slot positions used by checks and assertions.
	// ----------------------------------------------------------------
	localparam int SL_DISPLAY = 0;
	localparam int SL_USER    = 2;
	localparam int SL_TRQ_SRC = 3;
	localparam int SL_TRQ_1   = 4;
	localparam int SL_RAMP    = 8;
	localparam int SL_REV     = 9;
	localparam int SL_DUAL    = 12;
	localparam int SL_NS_SEL  = 13;
	localparam int SL_VOLT    = 14;
	localparam int SL_HIGH    = 16;
	localparam int SL_LOW     = 17;
	localparam int SL_WIDTH   = 18;
	localparam int SL_GAIN    = 19;
	localparam int SL_WC      = 24;

	logic [15:0] slots [0:dpb_pkg::NUM_SLOTS-1];
	logic        wr_pend;
	logic        rd_pend;
	logic [15:0] addr_q;
	logic        rating_large;
	logic        rejected;
	logic        hready_q;
	logic [31:0] rdata_q;
	logic        resp_q;

	logic        addr_take;
	logic        in_bank;
	logic [5:0]  slot;
	logic [15:0] wr_data;
	logic        wr_legal;
	logic        wr_bank;
	logic [15:0] trq_max;
	logic [15:0] cand_high;
	logic [15:0] cand_low;
	logic        time_ok;
	logic [2:0]  win_ok;
	logic [15:0] rd_val;

	// ----------------------------------------------------------------
	// Address decode.
	// ----------------------------------------------------------------

	// A transfer is taken in its address phase only when the bus is ready.
	assign addr_take = hsel_in & hready_in & htrans_in[1];
	assign slot      = 6'(addr_q - dpb_pkg::IDX_FIRST);
	assign wr_data   = hwdata_in[15:0];
	assign wr_bank   = wr_pend & in_bank;

	// Gaps inside the bank are decoded as absent so they store nothing.
	always_comb begin
		in_bank = (addr_q >= dpb_pkg::IDX_FIRST) && (addr_q <= dpb_pkg::IDX_LAST);
		if ((addr_q >= dpb_pkg::IDX_GAP_A_FIRST) && (addr_q <= dpb_pkg::IDX_GAP_A_LAST)) begin
			in_bank = 1'b0; // [RL18]
		end
		if ((addr_q >= dpb_pkg::IDX_GAP_B_FIRST) && (addr_q <= dpb_pkg::IDX_GAP_B_LAST)) begin
			in_bank = 1'b0; // [RL18]
		end
	end

	// ----------------------------------------------------------------
	// Bus phase tracking.
	// ----------------------------------------------------------------

	// Only whole-word writes are honoured; narrower ones complete silently.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			addr_q  <= 16'h0000;
		end else begin
			wr_pend <= addr_take & hwrite_in & (hsize_in == dpb_pkg::HSIZE_WORD);
			rd_pend <= addr_take & ~hwrite_in;
			if (addr_take) begin
				addr_q <= haddr_in[17:2];
			end
		end
	end

	// A read waits one cycle so that a write landing just before is seen.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			hready_q <= 1'b1;
		end else begin
			hready_q <= ~(addr_take & ~hwrite_in);
		end
	end

	// Every transfer is answered OKAY, including unmapped addresses.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			resp_q <= dpb_pkg::HRESP_OKAY;
		end else begin
			resp_q <= dpb_pkg::HRESP_OKAY;
		end
	end

	// ----------------------------------------------------------------
	// Write legality.
	// ----------------------------------------------------------------

	// The rating setting steers the quadrant torque ceiling.
	assign trq_max = rating_large ? dpb_pkg::TRQ_MAX_LARGE : dpb_pkg::TRQ_MAX_SMALL; // [RL3]

	// The time word pair is judged as one value, the other half kept.
	always_comb begin
		cand_high = (addr_q == dpb_pkg::IDX_NS_TIME_HIGH) ? wr_data : slots[SL_HIGH];
		cand_low  = (addr_q == dpb_pkg::IDX_NS_TIME_LOW) ? wr_data : slots[SL_LOW];
		time_ok   = ({cand_high, cand_low} >= dpb_pkg::TIME_MIN) &&
			({cand_high, cand_low} <= dpb_pkg::TIME_MAX); // [RL8]
	end

	// Each comparator is checked with the written value in place of its own.
	for (genvar c = 0; c < 3; c++) begin : g_win
		localparam logic [15:0] IDX_U = dpb_pkg::IDX_WC_VOLT_UPPER + 16'(3 * c);
		logic [15:0] cu;
		logic [15:0] cl;
		logic [15:0] ch;
		assign cu = (addr_q == IDX_U) ? wr_data : slots[SL_WC + 3 * c];
		assign cl = (addr_q == IDX_U + 16'h0001) ? wr_data : slots[SL_WC + 3 * c + 1];
		assign ch = (addr_q == IDX_U + 16'h0002) ? wr_data : slots[SL_WC + 3 * c + 2];
		dpb_window_check #(
			.BIPOLAR (c == 2)
		) u_check (
			.upper_in  (cu),
			.lower_in  (cl),
			.hyst_in   (ch),
			.valid_out (win_ok[c])
		); // [RL12]
	end

	// Range and code check of the pending write.
	always_comb begin
		case (addr_q)
			dpb_pkg::IDX_DISPLAY: wr_legal = wr_data <= dpb_pkg::MAX_CODE5; // [RL1]
			dpb_pkg::IDX_INIT_SCREEN: wr_legal = wr_data <= dpb_pkg::MAX_SCREEN;
			dpb_pkg::IDX_USER_AUTO,
			dpb_pkg::IDX_RAMP_HOLD,
			dpb_pkg::IDX_REV_PREVENT: wr_legal = wr_data <= dpb_pkg::MAX_BINARY; // [RL4]
			dpb_pkg::IDX_TRQ_SOURCE: wr_legal = wr_data <= dpb_pkg::MAX_CODE5; // [RL2]
			dpb_pkg::IDX_TRQ_FWD_POWER,
			dpb_pkg::IDX_TRQ_REV_REGEN,
			dpb_pkg::IDX_TRQ_REV_POWER,
			dpb_pkg::IDX_TRQ_FWD_REGEN: begin
				wr_legal = (wr_data == dpb_pkg::TRQ_DISABLE) || (wr_data <= trq_max); // [RL3]
			end
			dpb_pkg::IDX_DUAL_RATING: wr_legal = wr_data <= dpb_pkg::MAX_BINARY; // [RL5]
			dpb_pkg::IDX_NS_SELECT: wr_legal = wr_data <= dpb_pkg::MAX_BINARY; // [RL6]
			dpb_pkg::IDX_NS_START_VOLT,
			dpb_pkg::IDX_NS_DECEL_LVL: wr_legal = wr_data <= dpb_pkg::VOLT_MAX; // [RL7]
			dpb_pkg::IDX_NS_TIME_HIGH,
			dpb_pkg::IDX_NS_TIME_LOW: wr_legal = time_ok; // [RL8]
			dpb_pkg::IDX_NS_WIDTH: wr_legal = wr_data <= dpb_pkg::WIDTH_MAX; // [RL9]
			dpb_pkg::IDX_NS_PROP_GAIN: wr_legal = wr_data <= dpb_pkg::GAIN_MAX; // [RL10]
			dpb_pkg::IDX_NS_INTEGRAL: wr_legal = 1'b1; // [RL11]
			dpb_pkg::IDX_WC_VOLT_UPPER,
			dpb_pkg::IDX_WC_VOLT_LOWER,
			dpb_pkg::IDX_WC_VOLT_HYST: wr_legal = win_ok[0]; // [RL13] [RL14] [RL15]
			dpb_pkg::IDX_WC_CURR_UPPER,
			dpb_pkg::IDX_WC_CURR_LOWER,
			dpb_pkg::IDX_WC_CURR_HYST: wr_legal = win_ok[1]; // [RL13] [RL14] [RL15]
			dpb_pkg::IDX_WC_BIP_UPPER,
			dpb_pkg::IDX_WC_BIP_LOWER,
			dpb_pkg::IDX_WC_BIP_HYST: wr_legal = win_ok[2]; // [RL16]
			default: wr_legal = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Parameter storage.
	// ----------------------------------------------------------------

	// Reset value of each slot; comparators start on a legal wide window.
	function automatic logic [15:0] slot_reset(input logic [15:0] idx);
		case (idx)
			dpb_pkg::IDX_NS_TIME_LOW: slot_reset = dpb_pkg::RST_TIME_LOW;
			dpb_pkg::IDX_WC_VOLT_UPPER,
			dpb_pkg::IDX_WC_CURR_UPPER,
			dpb_pkg::IDX_WC_BIP_UPPER: slot_reset = dpb_pkg::RST_WIN_UPPER;
			dpb_pkg::IDX_WC_BIP_LOWER: slot_reset = dpb_pkg::RST_BIPOLAR_LOWER;
			default: slot_reset = dpb_pkg::RST_ZERO;
		endcase
	endfunction

	// One slot per address; a rejected write leaves the slot untouched.
	for (genvar g = 0; g < dpb_pkg::NUM_SLOTS; g++) begin : g_slot
		always_ff @(posedge clk_sys_in) begin
			if (rst_in) begin
				slots[g] <= slot_reset(dpb_pkg::IDX_FIRST + 16'(g));
			end else if (wr_bank && (slot == 6'(g)) && wr_legal) begin // [RL17] [RL18]
				slots[g] <= wr_data;
			end
		end
		assign params_out[g*16 +: 16] = slots[g];
	end

	// Changing the rating does not recheck limits already stored.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rating_large <= 1'b0;
		end else if (wr_pend && (addr_q == dpb_pkg::IDX_CONFIG)) begin
			rating_large <= hwdata_in[dpb_pkg::CFG_LARGE_BIT];
		end
	end

	// Records the verdict of the last write to a parameter.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rejected <= 1'b0;
		end else if (wr_bank) begin
			rejected <= ~wr_legal; // [RL17]
		end
	end

	// ----------------------------------------------------------------
	// Read path.
	// ----------------------------------------------------------------

	// Gaps and unmapped words read as zero.
	always_comb begin
		rd_val = 16'h0000;
		if (in_bank) begin
			rd_val = slots[slot];
		end else if (addr_q == dpb_pkg::IDX_CONFIG) begin
			rd_val[dpb_pkg::CFG_LARGE_BIT] = rating_large;
		end else if (addr_q == dpb_pkg::IDX_STATUS) begin
			rd_val[dpb_pkg::STS_REJECT_BIT] = rejected;
		end
	end

	// Read data is registered in the wait cycle and held until the next read.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd_pend) begin
			rdata_q <= {16'h0000, rd_val}; // [RL18]
		end
	end

	assign hrdata_out         = rdata_q;
	assign hreadyout_out      = hready_q;
	assign hresp_out          = resp_q;
	assign write_rejected_out = rejected;
	assign large_rating_out   = rating_large;

	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);

	logic [15:0] cur_val;
	logic        trq_stored_ok;
	logic        volt_win_ok;
	logic        curr_win_ok;
	logic        bip_win_ok;

	// Helper terms read only by the assertions below.
	always_comb begin
		cur_val = slots[slot];
		trq_stored_ok = 1'b1;
		for (int k = 0; k < 4; k++) begin
			if ((slots[SL_TRQ_1 + k] != dpb_pkg::TRQ_DISABLE) &&
				(slots[SL_TRQ_1 + k] > dpb_pkg::TRQ_MAX_SMALL)) begin
				trq_stored_ok = 1'b0;
			end
		end
		volt_win_ok = slots[SL_WC] >= slots[SL_WC + 1] + (slots[SL_WC + 2] << 1);
		curr_win_ok = slots[SL_WC + 3] >= slots[SL_WC + 4] + (slots[SL_WC + 5] << 1);
		bip_win_ok = $signed(slots[SL_WC + 6]) >=
			$signed(slots[SL_WC + 7]) + ($signed(slots[SL_WC + 8]) <<< 1);
	end

	a_display_code: assert property (slots[SL_DISPLAY] <= dpb_pkg::MAX_CODE5) // [RL1]
		else $error("display select holds an illegal code");

	a_trq_source: assert property (slots[SL_TRQ_SRC] <= dpb_pkg::MAX_CODE5) // [RL2]
		else $error("torque limit source holds an illegal code");

	a_trq_quadrant: assert property (trq_stored_ok) // [RL3]
		else $error("quadrant torque limit above ceiling");

	a_rating_binary: assert property ((slots[SL_DUAL] | slots[SL_NS_SEL]) <= 16'h0001) // [RL5]
		else $error("rating or non-stop select not binary");

	a_enable_binary: assert property ((slots[SL_USER] | slots[SL_RAMP]) <= 16'h0001 && // [RL4]
		slots[SL_REV] <= 16'h0001)
		else $error("binary enable holds an illegal value");

	a_volt_range: assert property (slots[SL_VOLT] <= dpb_pkg::VOLT_MAX) // [RL7]
		else $error("start voltage above range");

	a_time_range: assert property ({slots[SL_HIGH], slots[SL_LOW]} >= dpb_pkg::TIME_MIN && // [RL8]
		{slots[SL_HIGH], slots[SL_LOW]} <= dpb_pkg::TIME_MAX)
		else $error("decel time outside range");

	a_width_gain: assert property (slots[SL_WIDTH] <= dpb_pkg::WIDTH_MAX && // [RL9] [RL10]
		slots[SL_GAIN] <= dpb_pkg::GAIN_MAX)
		else $error("decel width or gain above range");

	a_window_gap: assert property (volt_win_ok) // [RL13]
		else $error("voltage window narrower than twice hysteresis");

	a_window_curr: assert property (curr_win_ok) // [RL13] [RL14]
		else $error("current window narrower than twice hysteresis");

	a_bipolar_range: assert property (bip_win_ok && // [RL16]
		$signed(slots[SL_WC + 7]) >= $signed(dpb_pkg::WIN_MIN_BIPOLAR))
		else $error("bipolar window outside signed range");

	a_reject_keeps: assert property ((wr_bank && !wr_legal) |=> // [RL17]
		(slots[$past(slot)] == $past(cur_val)) && write_rejected_out)
		else $error("rejected write changed a slot");

	a_accept_stores: assert property ((wr_bank && wr_legal) |=> // [RL17]
		(slots[$past(slot)] == $past(wr_data)) && !write_rejected_out)
		else $error("accepted write not stored");

	a_read_wait: assert property ((addr_take && !hwrite_in) |=>
		!hreadyout_out ##1 hreadyout_out)
		else $error("read wait state wrong");

	a_gap_zero: assert property ((rd_pend && !in_bank && addr_q >= dpb_pkg::IDX_FIRST && // [RL18]
		addr_q <= dpb_pkg::IDX_LAST) |=> hrdata_out == 32'h0000_0000)
		else $error("unused word read nonzero");

endmodule

`default_nettype wire

//--- hw/dpb_pkg.sv
// Purpose: Shared constants for the drive parameter bank.
// Assumes: Register indices are word indices; byte address is four times the index.
// Notes: Values are 16-bit words in the low half of the 32-bit bus.
// Function
// RL1 - Display select accepts codes zero to four.
// RL2 - Torque limit source accepts codes zero to four.
// RL3 - Quadrant limits: 0-200, or 0-180 large, or disable.
// RL4 - Auto-set, ramp hold, reverse prevent are binary enables.
// RL5 - Dual rating: constant or variable torque.
// RL6 - Non-stop select: off or constant voltage stop.
// RL7 - Start voltage and decel level 0 to 1000.0 V.
// RL8 - Decel time 32 bits, high/low, 0.01-3600.00 s.
// RL9 - Decel starting width 0.00 to 10.00 Hz.
// RL10 - Proportional gain 0.00 to 2.55.
// RL11 - Integral time fills full 16-bit word.
// RL12 - Three window comparators with upper, lower, hysteresis.
// RL13 - Upper within range, at least lower plus twice hysteresis.
// RL14 - Lower within range, at most upper minus twice hysteresis.
// RL15 - Hysteresis 0 to 10, capped by limit gap.
// RL16 - Bipolar comparator limits signed, -100 to 100.
// RL17 - Illegal writes rejected, stored value kept.
// RL18 - Unused addresses ignore writes, read zero.
`default_nettype none

package dpb_pkg;

	// ----------------------------------------------------------------
	// Register indices.
	// ----------------------------------------------------------------
	localparam logic [15:0] IDX_FIRST         = 16'h1327;
	localparam logic [15:0] IDX_DISPLAY       = 16'h1327;
	localparam logic [15:0] IDX_INIT_SCREEN   = 16'h1328;
	localparam logic [15:0] IDX_USER_AUTO     = 16'h1329;
	localparam logic [15:0] IDX_TRQ_SOURCE    = 16'h132a;
	localparam logic [15:0] IDX_TRQ_FWD_POWER = 16'h132b;
	localparam logic [15:0] IDX_TRQ_REV_REGEN = 16'h132c;
	localparam logic [15:0] IDX_TRQ_REV_POWER = 16'h132d;
	localparam logic [15:0] IDX_TRQ_FWD_REGEN = 16'h132e;
	localparam logic [15:0] IDX_RAMP_HOLD     = 16'h132f;
	localparam logic [15:0] IDX_REV_PREVENT   = 16'h1330;
	localparam logic [15:0] IDX_GAP_A_FIRST   = 16'h1331;
	localparam logic [15:0] IDX_GAP_A_LAST    = 16'h1332;
	localparam logic [15:0] IDX_DUAL_RATING   = 16'h1333;
	localparam logic [15:0] IDX_NS_SELECT     = 16'h1334;
	localparam logic [15:0] IDX_NS_START_VOLT = 16'h1335;
	localparam logic [15:0] IDX_NS_DECEL_LVL  = 16'h1336;
	localparam logic [15:0] IDX_NS_TIME_HIGH  = 16'h1337;
	localparam logic [15:0] IDX_NS_TIME_LOW   = 16'h1338;
	localparam logic [15:0] IDX_NS_WIDTH      = 16'h1339;
	localparam logic [15:0] IDX_NS_PROP_GAIN  = 16'h133a;
	localparam logic [15:0] IDX_NS_INTEGRAL   = 16'h133b;
	localparam logic [15:0] IDX_GAP_B_FIRST   = 16'h133c;
	localparam logic [15:0] IDX_GAP_B_LAST    = 16'h133e;
	localparam logic [15:0] IDX_WC_VOLT_UPPER = 16'h133f;
	localparam logic [15:0] IDX_WC_VOLT_LOWER = 16'h1340;
	localparam logic [15:0] IDX_WC_VOLT_HYST  = 16'h1341;
	localparam logic [15:0] IDX_WC_CURR_UPPER = 16'h1342;
	localparam logic [15:0] IDX_WC_CURR_LOWER = 16'h1343;
	localparam logic [15:0] IDX_WC_CURR_HYST  = 16'h1344;
	localparam logic [15:0] IDX_WC_BIP_UPPER  = 16'h1345;
	localparam logic [15:0] IDX_WC_BIP_LOWER  = 16'h1346;
	localparam logic [15:0] IDX_WC_BIP_HYST   = 16'h1347;
	localparam logic [15:0] IDX_LAST          = 16'h1347;
	localparam logic [15:0] IDX_CONFIG        = 16'h1380;
	localparam logic [15:0] IDX_STATUS        = 16'h1381;
	localparam int          NUM_SLOTS         = 33;

	// ----------------------------------------------------------------
	// Legal ranges and codes.
	// ----------------------------------------------------------------
	localparam logic [15:0] MAX_CODE5         = 16'h0004;
	localparam logic [15:0] MAX_BINARY        = 16'h0001;
	localparam logic [15:0] MAX_SCREEN        = 16'h00ca;
	localparam logic [15:0] TRQ_MAX_SMALL     = 16'h00c8;
	localparam logic [15:0] TRQ_MAX_LARGE     = 16'h00b4;
	localparam logic [15:0] TRQ_DISABLE       = 16'hffff;
	localparam logic [15:0] VOLT_MAX          = 16'h2710;
	localparam logic [31:0] TIME_MIN          = 32'h0000_0001;
	localparam logic [31:0] TIME_MAX          = 32'h0005_7e40;
	localparam logic [15:0] WIDTH_MAX         = 16'h03e8;
	localparam logic [15:0] GAIN_MAX          = 16'h00ff;
	localparam logic [15:0] WIN_MAX           = 16'h0064;
	localparam logic [15:0] WIN_MIN_BIPOLAR   = 16'hff9c;
	localparam logic [15:0] HYST_MAX          = 16'h000a;

	// ----------------------------------------------------------------
	// Reset values, field positions and bus codes.
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_ZERO          = 16'h0000;
	localparam logic [15:0] RST_TIME_LOW      = 16'h0001;
	localparam logic [15:0] RST_WIN_UPPER     = 16'h0064;
	localparam logic [15:0] RST_BIPOLAR_LOWER = 16'hff9c;
	localparam int          CFG_LARGE_BIT     = 0;
	localparam int          STS_REJECT_BIT    = 0;
	localparam logic [2:0]  HSIZE_WORD        = 3'h2;
	localparam logic        HRESP_OKAY        = 1'h0;

endpackage

`default_nettype wire

//--- hw/dpb_window_check.sv
// Purpose: Legality check of one window comparator setting triple.
// Assumes: Inputs are the candidate values after a pending write.
// Notes: Purely combinational; the bank registers the outcome.
`timescale 1ns/100ps
`default_nettype none

module dpb_window_check #(
	parameter bit BIPOLAR = 1'b0
) (
	input  wire logic [15:0] upper_in,
	input  wire logic [15:0] lower_in,
	input  wire logic [15:0] hyst_in,
	output logic             valid_out
);

	logic signed [17:0] up;
	logic signed [17:0] lo;
	logic signed [17:0] hy;
	logic signed [17:0] floor_lvl;

	// Widening to 18 bits keeps lower plus twice hysteresis from wrapping.
	always_comb begin
		up = 18'($signed(upper_in));
		lo = 18'($signed(lower_in));
		hy = 18'($signed(hyst_in));
		floor_lvl = BIPOLAR ? 18'($signed(dpb_pkg::WIN_MIN_BIPOLAR)) : 18'sh0; // [RL16]
		valid_out = (up >= floor_lvl) && (up <= 18'($signed(dpb_pkg::WIN_MAX))) && // [RL13]
			(lo >= floor_lvl) && (lo <= 18'($signed(dpb_pkg::WIN_MAX))) && // [RL14]
			(hy >= 18'sh0) && (hy <= 18'($signed(dpb_pkg::HYST_MAX))) && // [RL15]
			(up >= lo + (hy <<< 1)); // [RL13] [RL14] [RL15]
	end

endmodule

`default_nettype wire

//--- verif/tb_dpb_param_bank.sv
// Purpose: Self-checking bench for the drive parameter bank over AHB-Lite.
// Assumes: One master, single word transfers except one halfword write, hready looped back from hreadyout.
// Notes: A shadow model decides legality; a monitor compares read data in order.
`timescale 1ns/100ps
`default_nettype none

module tb_dpb_param_bank;

	// ----------------------------------------------------------------
	// Signals, shadow model and scoreboard.
	// ----------------------------------------------------------------
	logic        clk_sys_in = 1'b0;
	logic        rst_in     = 1'b1;
	logic        hsel_in    = 1'b0;
	logic        hwrite_in  = 1'b0;
	logic [1:0]  htrans_in  = 2'h0;
	logic [2:0]  hsize_in   = 3'h2;
	logic [31:0] haddr_in   = 32'h0;
	logic [31:0] hwdata_in  = 32'h0;
	logic [31:0] hrdata_out;
	logic        hreadyout_out;
	logic        hresp_out;
	logic        write_rejected_out;
	logic        large_rating_out;
	logic [dpb_pkg::NUM_SLOTS*16-1:0] params_out;
	logic [15:0] mem [0:32];
	logic        large_m;
	logic        rej_m;
	logic        rd_dp;
	logic        rd_w;
	logic [31:0] rq [$];
	logic [31:0] seed = 32'd55998;
	int          failures = 0;
	int          n_checks = 0;
	int          cycles = 0;
	localparam int LIMIT = 30000;
	logic [15:0] tidx [0:24] = '{16'h1335, 16'h1335, 16'h1336, 16'h1336, 16'h1339, 16'h1339,
		16'h133a, 16'h133a, 16'h1337, 16'h1338, 16'h1337, 16'h1338, 16'h1338, 16'h1337,
		16'h1338, 16'h1341, 16'h1340, 16'h1340, 16'h133f, 16'h133f, 16'h1345, 16'h1347,
		16'h1346, 16'h1331, 16'h1400};
	logic [15:0] tval [0:24] = '{16'h2710, 16'h2711, 16'h2710, 16'h2711, 16'h03e8, 16'h03e9,
		16'h00ff, 16'h0100, 16'h0000, 16'h0000, 16'h0005, 16'h7e40, 16'h7e41, 16'h0006,
		16'h0000, 16'h000a, 16'h0051, 16'h0050, 16'h0065, 16'h0063, 16'hff9b, 16'h000a,
		16'h0002, 16'h0007, 16'hffff};
	logic [15:0] cidx [0:7] = '{16'h1327, 16'h132a, 16'h1329, 16'h132f, 16'h1330, 16'h1333,
		16'h1334, 16'h1328};

	dpb_param_bank dut_u (
		.clk_sys_in         (clk_sys_in),
		.rst_in             (rst_in),
		.hsel_in            (hsel_in),
		.haddr_in           (haddr_in),
		.htrans_in          (htrans_in),
		.hwrite_in          (hwrite_in),
		.hsize_in           (hsize_in),
		.hwdata_in          (hwdata_in),
		.hready_in          (hreadyout_out),
		.hrdata_out         (hrdata_out),
		.hreadyout_out      (hreadyout_out),
		.hresp_out          (hresp_out),
		.write_rejected_out (write_rejected_out),
		.large_rating_out   (large_rating_out),
		.params_out         (params_out)
	);

	// Half period of 2 ns gives the 250 MHz system clock.
	always #2 clk_sys_in = ~clk_sys_in;

	// ----------------------------------------------------------------
	// Helpers.
	// ----------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic bit mapped(int g);
		return g >= 0 && g <= 32 && !(g inside {10, 11, 21, 22, 23});
	endfunction

	// Legality is worked out independently of the design, from the documented ranges.
	function automatic bit legal(int g, logic [15:0] v);
		logic [31:0] t;
		logic [15:0] w [0:2];
		int u, l, h, b, lo;
		if (g >= 24) begin
			b = 24 + (g - 24) / 3 * 3;
			w = '{mem[b], mem[b+1], mem[b+2]};
			w[g-b] = v;
			lo = (b == 30) ? -100 : 0;
			u = (b == 30) ? int'($signed(w[0])) : int'(w[0]);
			l = (b == 30) ? int'($signed(w[1])) : int'(w[1]);
			h = int'(w[2]);
			return u >= lo && u <= 100 && l >= lo && l <= 100 && h <= 10 && u >= l + 2 * h;
		end
		t = (g == 16) ? {v, mem[17]} : {mem[16], v};
		case (g)
			0, 3: return v <= 16'd4;
			1: return v <= 16'd202;
			2, 8, 9, 12, 13: return v <= 16'd1;
			4, 5, 6, 7: return v == 16'hffff || v <= (large_m ? 16'd180 : 16'd200);
			14, 15: return v <= 16'd10000;
			16, 17: return t >= 32'd1 && t <= 32'd360000;
			18: return v <= 16'd1000;
			19: return v <= 16'd255;
			default: return 1'b1;
		endcase
	endfunction

	task automatic model_reset();
		foreach (mem[g]) mem[g] = dpb_pkg::RST_ZERO;
		mem[17] = dpb_pkg::RST_TIME_LOW;
		mem[24] = dpb_pkg::RST_WIN_UPPER;
		mem[27] = dpb_pkg::RST_WIN_UPPER;
		mem[30] = dpb_pkg::RST_WIN_UPPER;
		mem[31] = dpb_pkg::RST_BIPOLAR_LOWER;
		large_m = 1'b0;
		rej_m = 1'b0;
	endtask

	task automatic check(logic [31:0] got, logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One AHB-Lite single transfer; entered and left just after a rising edge.
	task automatic xfer(logic w, logic [15:0] idx, logic [31:0] d, logic [2:0] sz);
		hsel_in <= 1'b1;
		haddr_in <= {14'h0, idx, 2'b00};
		hwrite_in <= w;
		hsize_in <= sz;
		htrans_in <= 2'h2;
		do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
		htrans_in <= 2'h0;
		hwdata_in <= d;
		do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
	endtask

	task automatic wr(logic [15:0] idx, logic [15:0] v);
		int g;
		logic [31:0] r;
		g = int'(idx) - 'h1327;
		r = rnd();
		if (idx == 16'h1380) large_m = v[0];
		else if (mapped(g)) begin
			rej_m = !legal(g, v);
			if (!rej_m) mem[g] = v;
		end
		xfer(1'b1, idx, {r[31:16], v}, dpb_pkg::HSIZE_WORD);
	endtask

	task automatic rd(logic [15:0] idx);
		int g;
		g = int'(idx) - 'h1327;
		if (idx == 16'h1380) rq.push_back({31'h0, large_m});
		else if (idx == 16'h1381) rq.push_back({31'h0, rej_m});
		else rq.push_back(mapped(g) ? {16'h0, mem[g]} : 32'h0);
		xfer(1'b0, idx, rnd(), dpb_pkg::HSIZE_WORD);
	endtask

	task automatic scan();
		for (int i = 'h1325; i <= 'h1349; i++) rd(16'(i));
		rd(16'h1380);
		rd(16'h1381);
	endtask

	task automatic final_report();
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Monitor: pairs each completed read with the oldest expectation.
	// ----------------------------------------------------------------
	always @(posedge clk_sys_in) begin
		if (rst_in) begin
			rd_dp <= 1'b0;
			rd_w <= 1'b0;
		end else begin
			// A read must show exactly one wait cycle before its data.
			if (rd_dp && hreadyout_out !== 1'b1) begin
				check(rd_w, 1'b0);
				rd_w <= 1'b1;
			end
			if (rd_dp && hreadyout_out === 1'b1) begin
				rd_dp <= 1'b0;
				check(rd_w, 1'b1);
				check(hresp_out, dpb_pkg::HRESP_OKAY);
				if (rq.size() == 0) check(hrdata_out, 32'hdead_beef);
				else check(hrdata_out, rq.pop_front());
			end
			if (hsel_in && htrans_in[1] && !hwrite_in && hreadyout_out === 1'b1) begin
				rd_dp <= 1'b1;
				rd_w <= 1'b0;
			end
		end
	end

	// Watchdog: a hang would otherwise leave the run without a verdict.
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles >= LIMIT) begin
			failures++;
			final_report();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] r;
		logic [15:0] idx;
		model_reset();
		repeat (12) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		@(posedge clk_sys_in);
		scan();
		$display("test reset values done");
		for (int i = 0; i < 8; i++) begin
			for (int v = 0; v <= 5; v++) begin
				wr(cidx[i], 16'(v));
				rd(cidx[i]);
				rd(16'h1381);
			end
		end
		wr(16'h1328, 16'd202);
		rd(16'h1328);
		wr(16'h1328, 16'd203);
		rd(16'h1328);
		$display("test codes done");
		for (int q = 'h132b; q <= 'h132e; q++) begin
			r = rnd();
			wr(16'(q), 16'd201);
			rd(16'(q));
			wr(16'(q), 16'hffff);
			rd(16'(q));
			wr(16'(q), 16'd200);
			rd(16'(q));
			wr(16'(q), 16'(r % 201));
			rd(16'(q));
		end
		wr(16'h1380, 16'h0001);
		rd(16'h1380);
		@(negedge clk_sys_in);
		check(large_rating_out, 1'b1);
		@(posedge clk_sys_in);
		wr(16'h132b, 16'd181);
		rd(16'h132b);
		rd(16'h1381);
		wr(16'h132e, 16'd180);
		rd(16'h132e);
		$display("test torque limits done");
		for (int i = 0; i < 25; i++) begin
			wr(tidx[i], tval[i]);
			rd(tidx[i]);
			rd(16'h1381);
			check(write_rejected_out, rej_m);
		end
		$display("test boundaries done");
		repeat (400) begin
			r = rnd();
			idx = 16'h1320 + 16'(r % 48);
			r = rnd();
			wr(idx, (r[1:0] == 2'b0) ? r[31:16] : 16'(int'(r % 260) - 30));
			rd(idx);
			check(write_rejected_out, rej_m);
		end
		$display("test random writes done");
		xfer(1'b1, 16'h1327, 32'h3, 3'h1);
		rd(16'h1327);
		wr(16'h1381, 16'h0001);
		rd(16'h1381);
		$display("test refused writes done");
		repeat (4) @(posedge clk_sys_in);
		foreach (mem[g]) if (mapped(g)) check(params_out[g*16 +: 16], mem[g]);
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		model_reset();
		@(posedge clk_sys_in);
		scan();
		repeat (4) @(posedge clk_sys_in);
		check(32'(rq.size()), 32'h0);
		$display("test second reset done");
		final_report();
	end

endmodule

`default_nettype wire
